//--- core/psh_host_port.v
// Paged serial host port: interface pick, boot straps, SPI slave, paging and mailbox
//
// Notes on behaviour
// - After reset, pick pin low selects two-wire, high selects SPI.
// - Seven-bit register address; register space split into pages of 128.
// - Offset 0x7F on every page is the page selector.
// - Page p maps offsets 0x00..0x7E to p*0x80..p*0x80+0x7E.
// - Pages 0..9 are direct registers; pages 10 and up share a mailbox.
// - Target mask then read bit loads mailbox from the chosen instance.
// - Write bit copies mailbox values into the chosen instance.
// - Mailbox writes ignored until PLL locked and device ready.
// - While not ready, every SPI read returns zero.
// - Identification register returns the device code once boot completes.
// - Stored-configuration device samples three boot pins after reset; else ignores them.
// - Half duplex: input ignored during read data, driver off during writes.
// - Driver on at edge taking last read-address bit, off at chip-select rise.
// - Clock level at chip-select fall picks MSb-first (low) or LSb-first (high).
// - Transaction is one flag bit, seven address bits, eight data bits.
// - Chip select held low continues a burst with address increment per byte.
// - LSb-first sends flag, A0..A6, then D0..D7.
// - MSb-first sends address and data most significant bit first.
// - PLL lock is master status bit 3, zero locked; ready is info bit 7.
`timescale 1ns/1ps
`include "psh_regs.vh"

module psh_host_port (
    ref_clk,
    rst_n,
    chip_select_iface_pick,
    sck_pin,
    si_pin,
    boot_config_pin_0,
    boot_config_pin_1,
    boot_config_pin_2,
    config_stored,
    boot_ready,
    sys_pll_unlock,
    serial_out_pin,
    serial_out_oe,
    iface_is_spi,
    iface_picked,
    boot_config_sel
);
    input wire ref_clk;
    input wire rst_n;
    input wire chip_select_iface_pick;
    input wire sck_pin;
    input wire si_pin;
    input wire boot_config_pin_0;
    input wire boot_config_pin_1;
    input wire boot_config_pin_2;
    input wire config_stored;
    input wire boot_ready;
    input wire sys_pll_unlock;
    output reg serial_out_pin;
    output reg serial_out_oe;
    output reg iface_is_spi;
    output reg iface_picked;
    output reg [2:0] boot_config_sel;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HDR = 3'b010;
    localparam [2:0] ST_DATA = 3'b100;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg [7:0] dir_mem [0:`PSH_DIR_DEPTH-1];
    reg [7:0] mbox_mem [0:`PSH_MB_SIZE-1];
    reg [7:0] inst_mem [0:`PSH_MB_INST_DEPTH-1];
    reg [7:0] page_reg;
    reg [7:0] mb_target_reg;
    reg [1:0] mb_hs_reg;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    reg cs_meta_reg;
    reg cs_sync_reg;
    reg sck_meta_reg;
    reg sck_sync_reg;
    reg si_meta_reg;
    reg si_sync_reg;
    reg [2:0] bcfg_meta_reg;
    reg [2:0] bcfg_sync_reg;
    reg cs_prev_reg;
    reg sck_prev_reg;

    // ------------------------------------------------------------
    // SPI engine state
    // ------------------------------------------------------------
    reg [2:0] state_reg;
    reg [2:0] bit_cnt_reg;
    reg hdr_first_reg;
    reg rd_flag_reg;
    reg lsb_first_reg;
    reg [6:0] addr_reg;
    reg [7:0] shift_reg;
    reg [7:0] rd_byte_reg;
    reg [2:0] pick_cnt_reg;

    wire cs_fall;
    wire cs_rise;
    wire sck_rise;
    wire sck_fall;
    wire spi_on;
    wire mb_ok;
    wire [6:0] addr_next;
    wire [7:0] byte_next;
    wire [7:0] wr_byte;

    assign spi_on = iface_picked & iface_is_spi;
    assign cs_fall = spi_on & cs_prev_reg & ~cs_sync_reg;
    assign cs_rise = ~cs_prev_reg & cs_sync_reg;
    assign sck_rise = spi_on & ~cs_sync_reg & sck_sync_reg & ~sck_prev_reg;
    assign sck_fall = spi_on & ~cs_sync_reg & ~sck_sync_reg & sck_prev_reg;
    assign mb_ok = boot_ready & ~sys_pll_unlock;
    assign addr_next = shift_in7(addr_reg, si_sync_reg, lsb_first_reg);
    assign byte_next = rd_read(addr_reg + 7'h01);
    assign wr_byte = shift_in8(shift_reg, si_sync_reg, lsb_first_reg);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Shift one serial bit into a 7-bit field in the chosen order
    function [6:0] shift_in7;
        input [6:0] cur;
        input b;
        input lsb;
        begin
            if (lsb) begin
                shift_in7 = {b, cur[6:1]};
            end else begin
                shift_in7 = {cur[5:0], b};
            end
        end
    endfunction

    function [7:0] shift_in8;
        input [7:0] cur;
        input b;
        input lsb;
        begin
            if (lsb) begin
                shift_in8 = {b, cur[7:1]};
            end else begin
                shift_in8 = {cur[6:0], b};
            end
        end
    endfunction

    // Bit of a read byte sent at a given position in the chosen order
    function out_bit;
        input [7:0] d;
        input [2:0] pos;
        input lsb;
        begin
            if (lsb) begin
                out_bit = d[pos];
            end else begin
                out_bit = d[3'h7 - pos];
            end
        end
    endfunction

    // Lowest selected mailbox instance
    function [1:0] mb_index;
        input [7:0] m;
        begin
            if (m[0]) begin
                mb_index = 2'h0;
            end else if (m[1]) begin
                mb_index = 2'h1;
            end else if (m[2]) begin
                mb_index = 2'h2;
            end else begin
                mb_index = 2'h3;
            end
        end
    endfunction

    // Register read through the current page
    function [7:0] rd_read;
        input [6:0] a;
        begin
            rd_read = 8'h00;
            if (a == `PSH_PAGE_SEL) begin
                rd_read = page_reg;
            end else if (page_reg < `PSH_DIR_PAGES) begin
                if (page_reg == 8'h00 && a == `PSH_ID_OFS) begin
                    rd_read = `PSH_ID_CODE;
                end else if (page_reg == 8'h00 && a == `PSH_INFO_OFS) begin
                    rd_read[`PSH_INFO_READY] = boot_ready;
                end else if (page_reg == 8'h00 && a == `PSH_MSTAT_OFS) begin
                    rd_read[`PSH_MSTAT_LOCK] = sys_pll_unlock;
                end else begin
                    rd_read = dir_mem[{page_reg[3:0], a}];
                end
            end else if (a == `PSH_MB_TARGET_OFS) begin
                rd_read = mb_target_reg;
            end else if (a == `PSH_MB_HS_OFS) begin
                rd_read = {6'h00, mb_hs_reg};
            end else if (a < `PSH_MB_SIZE) begin
                rd_read = mbox_mem[a[3:0]];
            end
            if (!boot_ready) begin
                rd_read = 8'h00;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and edge history
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            sck_meta_reg <= 1'b0;
            sck_sync_reg <= 1'b0;
            si_meta_reg <= 1'b0;
            si_sync_reg <= 1'b0;
            bcfg_meta_reg <= 3'h0;
            bcfg_sync_reg <= 3'h0;
            cs_prev_reg <= 1'b1;
            sck_prev_reg <= 1'b0;
        end else begin
            cs_meta_reg <= chip_select_iface_pick;
            cs_sync_reg <= cs_meta_reg;
            sck_meta_reg <= sck_pin;
            sck_sync_reg <= sck_meta_reg;
            si_meta_reg <= si_pin;
            si_sync_reg <= si_meta_reg;
            bcfg_meta_reg <= {boot_config_pin_2, boot_config_pin_1, boot_config_pin_0};
            bcfg_sync_reg <= bcfg_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            sck_prev_reg <= sck_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Interface pick and boot straps, caught once after release
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            pick_cnt_reg <= 3'h0;
            iface_picked <= 1'b0;
            iface_is_spi <= 1'b0;
            boot_config_sel <= 3'h0;
        end else if (!iface_picked) begin
            pick_cnt_reg <= pick_cnt_reg + 3'h1;
            if (pick_cnt_reg == `PSH_PICK_DELAY) begin
                iface_picked <= 1'b1;
                iface_is_spi <= (cs_sync_reg == `PSH_PICK_SPI);
                if (config_stored) begin
                    boot_config_sel <= bcfg_sync_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // SPI engine, registers and mailbox transfers
    // ------------------------------------------------------------
    integer i;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 3'h0;
            hdr_first_reg <= 1'b0;
            rd_flag_reg <= 1'b0;
            lsb_first_reg <= 1'b0;
            addr_reg <= 7'h00;
            shift_reg <= 8'h00;
            rd_byte_reg <= 8'h00;
            serial_out_pin <= 1'b0;
            serial_out_oe <= 1'b0;
            page_reg <= `PSH_PAGE_RST;
            mb_target_reg <= 8'h00;
            mb_hs_reg <= 2'h0;
        end else begin
            // Mailbox handshakes complete in one cycle; a host set below wins
            if (mb_hs_reg[`PSH_MB_HS_RD]) begin
                if (mb_target_reg[3:0] != 4'h0) begin
                    for (i = 0; i < `PSH_MB_SIZE; i = i + 1) begin
                        mbox_mem[i] <= inst_mem[{mb_index(mb_target_reg), i[3:0]}];
                    end
                end
                mb_hs_reg[`PSH_MB_HS_RD] <= 1'b0;
            end else if (mb_hs_reg[`PSH_MB_HS_WR]) begin
                if (mb_target_reg[3:0] != 4'h0) begin
                    for (i = 0; i < `PSH_MB_SIZE; i = i + 1) begin
                        inst_mem[{mb_index(mb_target_reg), i[3:0]}] <= mbox_mem[i];
                    end
                end
                mb_hs_reg[`PSH_MB_HS_WR] <= 1'b0;
            end
            if (cs_rise) begin
                state_reg <= ST_IDLE;
                serial_out_oe <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (cs_fall) begin
                            lsb_first_reg <= sck_sync_reg;
                            bit_cnt_reg <= 3'h0;
                            hdr_first_reg <= 1'b1;
                            state_reg <= ST_HDR;
                        end
                    end
                    ST_HDR: begin
                        if (sck_rise) begin
                            if (hdr_first_reg) begin
                                rd_flag_reg <= (si_sync_reg == `PSH_FLAG_READ);
                                hdr_first_reg <= 1'b0;
                            end else begin
                                addr_reg <= addr_next;
                                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                                if (bit_cnt_reg == 3'h6) begin
                                    bit_cnt_reg <= 3'h0;
                                    state_reg <= ST_DATA;
                                    if (rd_flag_reg) begin
                                        rd_byte_reg <= rd_read(addr_next);
                                        serial_out_oe <= 1'b1;
                                        serial_out_pin <= out_bit(rd_read(addr_next), 3'h0,
                                            lsb_first_reg);
                                    end
                                end
                            end
                        end
                    end
                    ST_DATA: begin
                        if (rd_flag_reg) begin
                            // Serial input is not looked at while read data goes out
                            if (sck_rise) begin
                                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                                if (bit_cnt_reg == 3'h7) begin
                                    addr_reg <= addr_reg + 7'h01;
                                    rd_byte_reg <= byte_next;
                                end
                            end else if (sck_fall) begin
                                serial_out_pin <= out_bit(rd_byte_reg, bit_cnt_reg,
                                    lsb_first_reg);
                            end
                        end else if (sck_rise) begin
                            shift_reg <= wr_byte;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == 3'h7) begin
                                addr_reg <= addr_reg + 7'h01;
                                if (addr_reg == `PSH_PAGE_SEL) begin
                                    page_reg <= wr_byte;
                                end else if (page_reg < `PSH_DIR_PAGES) begin
                                    if (!(page_reg == 8'h00 && addr_reg <= `PSH_MSTAT_OFS)) begin
                                        dir_mem[{page_reg[3:0], addr_reg}] <= wr_byte;
                                    end
                                end else if (mb_ok) begin
                                    if (addr_reg == `PSH_MB_TARGET_OFS) begin
                                        mb_target_reg <= wr_byte;
                                    end else if (addr_reg == `PSH_MB_HS_OFS) begin
                                        mb_hs_reg <= mb_hs_reg | wr_byte[1:0];
                                    end else if (addr_reg < `PSH_MB_SIZE) begin
                                        mbox_mem[addr_reg[3:0]] <= wr_byte;
                                    end
                                end
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // psh_host_port

//--- core/psh_regs.vh
// Register offsets, field positions, reset values and counts of the paged host port
`ifndef PSH_REGS_VH
`define PSH_REGS_VH
// Page selector sits at the same offset on every page
`define PSH_PAGE_SEL 7'h7F
`define PSH_PAGE_RST 8'h00
// Read-only registers on page 0
`define PSH_ID_OFS 7'h00
`define PSH_INFO_OFS 7'h01
`define PSH_MSTAT_OFS 7'h02
`define PSH_INFO_READY 7
`define PSH_MSTAT_LOCK 3
// Identification code value is arbitrary
`define PSH_ID_CODE 8'h5A
// Paging
`define PSH_DIR_PAGES 8'h0A
`define PSH_DIR_DEPTH 1280
// Mailbox pages
`define PSH_MB_SIZE 16
`define PSH_MB_NUM_INST 4
`define PSH_MB_INST_DEPTH 64
`define PSH_MB_TARGET_OFS 7'h7C
`define PSH_MB_HS_OFS 7'h7D
`define PSH_MB_HS_RD 0
`define PSH_MB_HS_WR 1
// Interface pick level and the delay before straps are caught
`define PSH_PICK_SPI 1'b1
`define PSH_PICK_DELAY 3'h4
// Read/write flag values
`define PSH_FLAG_READ 1'b1
`endif

//--- bench/psh_host_model.sv
// Host processor model acting as serial bus master of the paged host port
`timescale 1ns/1ps
module psh_host_model (
    input wire logic ref_clk,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    // ----
    // Framing
    // ----
    // Reference cycles per 32 ns half of the 64 ns link period
    localparam int HALF = 8;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // One access: flag, address, then n data bytes, low byte of wdat first
    task automatic xfer(input logic lsb, input logic rd, input logic [6:0] addr,
                        input logic [31:0] wdat, input int n);
        logic b;
        int j;
        sck = lsb;
        wt(HALF);
        cs_n = 1'b0;
        wt(HALF);
        for (int k = 0; k < 8 + 8 * n; k++) begin
            j = (k - 8) % 8;
            if (k == 0) b = rd;
            else if (k < 8) b = lsb ? addr[k-1] : addr[7-k];
            else if (rd) b = 1'($urandom_range(1));
            else b = lsb ? wdat[k-8] : wdat[8 * ((k - 8) / 8) + 7 - j];
            sck = 1'b0;
            si = b;
            wt(HALF);
            // Read data is taken just before the rise that closes its bit slot
            if (rd && k >= 8) begin
                // Undriven line reads as unknown
                b = serial_out_oe ? serial_out_pin : 1'bx;
                if (lsb) rx_byte[j] = b;
                else rx_byte[7-j] = b;
            end
            sck = 1'b1;
            wt(HALF);
            if (rd && k >= 8 && j == 7) begin
                rx_valid = 1'b1;
                wt(1);
                rx_valid = 1'b0;
            end
        end
        if (!lsb) sck = 1'b0;
        wt(HALF);
        cs_n = 1'b1;
        si = ~si;
        wt(2 * HALF);
    endtask
endmodule // psh_host_model

//--- bench/psh_host_port_assertions.sv
// Port-level assertions of the paged host port
`timescale 1ns/1ps
module psh_host_port_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chip_select_iface_pick,
    input wire logic sck_pin,
    input wire logic si_pin,
    input wire logic boot_config_pin_0,
    input wire logic boot_config_pin_1,
    input wire logic boot_config_pin_2,
    input wire logic config_stored,
    input wire logic serial_out_oe,
    input wire logic iface_is_spi,
    input wire logic iface_picked,
    input wire logic [2:0] boot_config_sel
);
    // ----
    // Own view of a frame: synced pins and a count of clock rises
    // ----
    logic [1:0] cs_s, sck_s, si_s;
    logic sck_d, rd_flag;
    logic [3:0] rise_cnt;
    always_ff @(posedge ref_clk) begin
        cs_s <= {cs_s[0], chip_select_iface_pick};
        sck_s <= {sck_s[0], sck_pin};
        si_s <= {si_s[0], si_pin};
        sck_d <= sck_s[1];
        if (!rst_n || cs_s[1] || !iface_picked) begin
            rise_cnt <= 4'h0;
            rd_flag <= 1'b0;
        end else if (sck_s[1] && !sck_d) begin
            if (rise_cnt != 4'hF) rise_cnt <= rise_cnt + 4'h1;
            if (rise_cnt == 4'h0) rd_flag <= si_s[1];
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_release; $rose(rst_n); endsequence
    sequence s_cs_idle; chip_select_iface_pick [*6]; endsequence
    sequence s_addr_done; rd_flag && $rose(rise_cnt == 4'h8); endsequence
    property p_pick_time; s_release |-> ##[3:7] iface_picked; endproperty
    property p_pick_value;
        $rose(iface_picked) |-> iface_is_spi == chip_select_iface_pick && boot_config_sel ==
            (config_stored ? {boot_config_pin_2, boot_config_pin_1, boot_config_pin_0} : 3'h0);
    endproperty
    property p_pick_hold;
        iface_picked |=> iface_picked && $stable(iface_is_spi) && $stable(boot_config_sel);
    endproperty
    property p_oe_idle; s_cs_idle |-> !serial_out_oe; endproperty
    property p_oe_off; $rose(chip_select_iface_pick) |-> ##[1:6] !serial_out_oe; endproperty
    property p_oe_stand; serial_out_oe && !chip_select_iface_pick |=> serial_out_oe; endproperty
    property p_oe_write; !cs_s[1] && rise_cnt != 4'h0 && !rd_flag |-> !serial_out_oe; endproperty
    property p_oe_early; !cs_s[1] && rise_cnt < 4'h7 |-> !serial_out_oe; endproperty
    property p_oe_on; s_addr_done |-> ##[0:3] serial_out_oe; endproperty
    a_pick_time: assert property (p_pick_time)
        else $error("interface pick not caught in time");
    a_pick_value: assert property (p_pick_value)
        else $error("picked interface or boot selection wrong");
    a_pick_hold: assert property (p_pick_hold)
        else $error("picked interface changed after boot");
    a_oe_idle: assert property (p_oe_idle)
        else $error("serial out driven while chip select high");
    a_oe_off: assert property (p_oe_off)
        else $error("serial out driver not released after chip select rise");
    a_oe_stand: assert property (p_oe_stand)
        else $error("serial out driver dropped inside frame");
    a_oe_write: assert property (p_oe_write)
        else $error("serial out driven during write");
    a_oe_early: assert property (p_oe_early)
        else $error("serial out driven before address complete");
    a_oe_on: assert property (p_oe_on)
        else $error("serial out driver late after last address bit");
endmodule // psh_host_port_chk

bind psh_host_port psh_host_port_chk u_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .chip_select_iface_pick(chip_select_iface_pick),
    .sck_pin(sck_pin),
    .si_pin(si_pin),
    .boot_config_pin_0(boot_config_pin_0),
    .boot_config_pin_1(boot_config_pin_1),
    .boot_config_pin_2(boot_config_pin_2),
    .config_stored(config_stored),
    .serial_out_oe(serial_out_oe),
    .iface_is_spi(iface_is_spi),
    .iface_picked(iface_picked),
    .boot_config_sel(boot_config_sel)
);

//--- bench/tb_psh_host_port.sv
// Self-checking bench of the paged host port
`timescale 1ns/1ps
`include "psh_regs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_psh_host_port;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pick = 1'b1;
    logic pick_phase = 1'b1;
    logic config_stored = 1'b0;
    logic boot_ready = 1'b0;
    logic sys_pll_unlock = 1'b1;
    logic [2:0] boot_pins = 3'h0;
    logic cs_n, sck, si, rx_valid, serial_out_pin, serial_out_oe, iface_is_spi, iface_picked;
    logic [7:0] rx_byte, ex;
    logic [2:0] boot_config_sel;
    logic [31:0] mb;
    logic [7:0] pv [10];
    logic [7:0] q_exp [$];
    int n_tests = 0;
    int num_errors = 0;
    wire cs_pin = pick_phase ? pick : cs_n;
    always #2 ref_clk = ~ref_clk;
    psh_host_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .chip_select_iface_pick(cs_pin),
        .sck_pin(sck), .si_pin(si), .boot_config_pin_0(boot_pins[0]),
        .boot_config_pin_1(boot_pins[1]), .boot_config_pin_2(boot_pins[2]),
        .config_stored(config_stored), .boot_ready(boot_ready), .sys_pll_unlock(sys_pll_unlock),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .iface_is_spi(iface_is_spi), .iface_picked(iface_picked),
        .boot_config_sel(boot_config_sel));
    psh_host_model u_host (.ref_clk(ref_clk), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .cs_n(cs_n), .sck(sck), .si(si), .rx_byte(rx_byte),
        .rx_valid(rx_valid));
    // ----
    // Result watcher
    // ----
    always @(posedge ref_clk) begin
        if (rx_valid) begin
            ex = (q_exp.size() != 0) ? q_exp.pop_front() : ~rx_byte;
            `CHK("read data", ex, rx_byte)
        end
    end
    task automatic wr(input logic [6:0] a, input logic [31:0] d, input int n = 1);
        u_host.xfer(1'($urandom_range(1)), 1'b0, a, d, n);
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] e, input int n = 1,
                      input logic [7:0] m = 8'hFF);
        for (int i = 0; i < n; i++) q_exp.push_back(e[8*i +: 8] & m);
        u_host.xfer(1'($urandom_range(1)), 1'b1, a, 32'h0, n);
    endtask
    task automatic boot(input logic p, input logic st);
        pick_phase = 1'b1;
        pick = p;
        config_stored = st;
        boot_pins = 3'($urandom_range(7));
        rst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 50 && iface_picked !== 1'b1; i++) @(negedge ref_clk);
        `CHK("iface_picked", 1'b1, iface_picked)
        `CHK("iface_is_spi", p, iface_is_spi)
        `CHK("boot_config_sel", st ? boot_pins : 3'h0, boot_config_sel)
        repeat (8) @(negedge ref_clk);
        pick_phase = 1'b0;
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    initial begin
        void'($urandom(32'h75F85594));
        boot(1'b0, 1'b1);
        boot(1'b1, 1'b0);
        boot(1'b1, 1'b1);
        rd(`PSH_ID_OFS, 32'h0);
        rd(`PSH_INFO_OFS, 32'h0);
        boot_ready = 1'b1;
        rd(`PSH_ID_OFS, `PSH_ID_CODE);
        rd(`PSH_INFO_OFS, 32'h80, 1, 8'h80);
        rd(`PSH_MSTAT_OFS, 32'h08, 1, 8'h08);
        sys_pll_unlock = 1'b0;
        rd(`PSH_MSTAT_OFS, 32'h00, 1, 8'h08);
        wr(`PSH_ID_OFS, 32'hFF);
        rd(`PSH_ID_OFS, `PSH_ID_CODE);
        for (int p = 0; p < 10; p++) begin
            pv[p] = 8'($urandom);
            wr(`PSH_PAGE_SEL, p);
            wr(7'h7E, pv[p]);
        end
        for (int p = 9; p >= 0; p--) begin
            wr(`PSH_PAGE_SEL, p);
            rd(7'h7E, {16'h0, p[7:0], pv[p]}, 2);
        end
        mb = $urandom;
        wr(`PSH_PAGE_SEL, 32'h0A);
        wr(`PSH_MB_TARGET_OFS, 32'h01);
        wr(7'h00, mb[15:0], 2);
        rd(7'h00, mb[15:0], 2);
        wr(`PSH_MB_HS_OFS, 32'h02);
        sys_pll_unlock = 1'b1;
        wr(7'h00, ~mb, 2);
        rd(7'h00, mb[15:0], 2);
        sys_pll_unlock = 1'b0;
        wr(`PSH_MB_TARGET_OFS, 32'h02);
        wr(7'h00, mb[31:16], 2);
        wr(`PSH_MB_HS_OFS, 32'h02);
        wr(`PSH_MB_TARGET_OFS, 32'h01);
        wr(`PSH_MB_HS_OFS, 32'h01);
        rd(7'h00, mb[15:0], 2);
        wr(`PSH_MB_TARGET_OFS, 32'h02);
        wr(`PSH_MB_HS_OFS, 32'h01);
        wr(`PSH_PAGE_SEL, 32'h0E);
        rd(7'h00, mb[31:16], 2);
        `CHK("pending reads", 0, q_exp.size())
        conclude();
    end
    initial begin
        #300000;
        num_errors++;
        conclude();
    end
endmodule // tb_psh_host_port
